// File: qa_eval_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module qa_eval_asserts
(
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic SRST,
  // Answer events
  input wire logic ANSWER_VALID,
  input wire logic ANSWER_CORRECT,
  input wire logic WIN2_END,
  // Results
  input wire logic NEW_CYCLE,
  input wire logic NEW_QUESTION,
  input wire logic WD_ACTION,
  input wire logic IRQ,
  // APB
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic [7:0] PADDR,
  input wire logic PREADY,
  input wire logic PSLVERR
);
  // Single clock domain
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (SRST);
  chk_reset_quiet: assert property ($fell(SRST) |-> !NEW_CYCLE && !WD_ACTION && !IRQ)
    else $error("output active after reset");
  chk_question_pass: assert property (NEW_QUESTION |-> NEW_CYCLE)
    else $error("question without cycle start");
  chk_pass_answer: assert property (NEW_QUESTION |-> $past(ANSWER_VALID) && $past(ANSWER_CORRECT))
    else $error("new question not after a correct answer");
  chk_cycle_cause: assert property (NEW_CYCLE |-> $past(ANSWER_VALID) || $past(WIN2_END))
    else $error("cycle start without closing event");
  chk_pulse_once: assert property (NEW_CYCLE |=> !NEW_CYCLE)
    else $error("cycle start longer than one clock");
  chk_action_sticky: assert property (WD_ACTION |=> WD_ACTION)
    else $error("action dropped");
  chk_action_cause: assert property ($rose(WD_ACTION) |-> !NEW_QUESTION)
    else $error("action on a passed cycle");
  chk_ready_zero: assert property (PSEL |-> PREADY)
    else $error("bus not ready");
  chk_error_map: assert property (PSEL && PENABLE |-> PSLVERR == (PADDR > 8'h0C || PADDR[1:0] != 2'h0))
    else $error("bus error flag wrong");
endmodule : qa_eval_asserts
bind qa_watchdog_answer_evaluator qa_eval_asserts u_chk (.REF_CLK(REF_CLK), .SRST(SRST),
  .ANSWER_VALID(ANSWER_VALID), .ANSWER_CORRECT(ANSWER_CORRECT), .WIN2_END(WIN2_END),
  .NEW_CYCLE(NEW_CYCLE), .NEW_QUESTION(NEW_QUESTION), .WD_ACTION(WD_ACTION), .IRQ(IRQ),
  .PSEL(PSEL), .PENABLE(PENABLE), .PADDR(PADDR), .PREADY(PREADY), .PSLVERR(PSLVERR));
`default_nettype wire

// File: qa_eval_pkg.sv
package qa_eval_pkg;
  // Answer counting
  localparam int ANSW_CNT_W = 2;
  localparam logic [1:0] ANSW_CNT_LAST = 2'h3;
  localparam logic [1:0] ANSW_CNT_THIRD = 2'h2;
  localparam logic [1:0] ANSW_CNT_RST = 2'h0;
  // Failure counter
  localparam int FAIL_CNT_W = 4;
  localparam logic [3:0] FAIL_CNT_RST = 4'h0;
  localparam logic [3:0] FAIL_CNT_MAX = 4'hF;
  localparam logic [3:0] FAIL_LIMIT_RST = 4'hF;
  // Answer scheme select value for multi-answer mode
  localparam logic SCHEME_MULTI = 1'b0;
  // APB register offsets (byte addresses)
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;
  // CTRL fields
  localparam int CTRL_SCHEME_BIT = 0;
  localparam int CTRL_LIMIT_LSB = 4;
  // STATUS fields
  localparam int ST_ANSW_ERR_BIT = 0;
  localparam int ST_WATCHDOG_ERROR_FLAG_BIT = 1;
  localparam int ST_ACTION_BIT = 2;
  localparam int ST_CNT_LSB = 4;
  localparam int ST_FAIL_LSB = 8;
  localparam int ST_WIN2_BIT = 12;
  // Interrupt event bits
  localparam int IRQ_W = 3;
  localparam int EV_CYCLE_END = 0;
  localparam int EV_FAIL = 1;
  localparam int EV_ACTION = 2;
  // Cycle outcome
  typedef enum logic [1:0] {OUT_NONE, OUT_PASS, OUT_FAIL} outcome_t;
endpackage : qa_eval_pkg

// File: qa_fail_counter.sv
`timescale 1ns/100ps
`default_nettype none
module qa_fail_counter
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Verdict link
  qa_verdict_if.cnt vd
);
  import qa_eval_pkg::*;

  logic [3:0] fail_r;
  logic action_r;

  // Saturating up/down count; down on pass, up on fail
  always_ff @(posedge clk)
  begin
    if (rst)
      fail_r <= FAIL_CNT_RST;
    else if (vd.end_pulse && vd.pass && fail_r != FAIL_CNT_RST)
      fail_r <= fail_r - 4'h1;
    else if (vd.end_pulse && !vd.pass && fail_r != FAIL_CNT_MAX)
      fail_r <= fail_r + 4'h1;
  end

  // Action latches on the failure that reaches the limit
  always_ff @(posedge clk)
  begin
    if (rst)
      action_r <= 1'b0;
    else if (vd.end_pulse && !vd.pass && (fail_r + 4'h1) == vd.limit)
      action_r <= 1'b1;
  end

  assign vd.fail_cnt = fail_r;
  assign vd.action = action_r;
endmodule : qa_fail_counter
`default_nettype wire

// File: qa_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module qa_host_model
(
  // Clock
  input wire logic clk,
  // Answer and window strobes
  output logic answer_valid,
  output logic answer_correct,
  output logic win1_end,
  output logic win2_end
);
  // Idle at time zero
  initial {answer_valid, answer_correct, win1_end, win2_end} = 4'h0;
  // One answer after a random pause; correct is left at the inverse of the answer given
  task automatic send(input logic ok);
    repeat ($urandom_range(2, 0)) @(posedge clk);
    @(posedge clk);
    answer_valid <= 1'b1;
    answer_correct <= ok;
    @(posedge clk);
    answer_valid <= 1'b0;
    answer_correct <= ~ok;
  endtask : send
  // One-clock window end strobe
  task automatic strobe(input logic second);
    @(posedge clk);
    win1_end <= !second;
    win2_end <= second;
    @(posedge clk);
    win1_end <= 1'b0;
    win2_end <= 1'b0;
  endtask : strobe
  // Early answers, window one ends, late answers, window two ends if short
  task automatic run(input int ok1, input int bad1, input int ok2, input int bad2);
    for (int i = 0; i < ok1 + bad1; i++) send(i < ok1);
    if (ok1 + bad1 < 4)
    begin
      strobe(1'b0);
      for (int i = 0; i < ok2 + bad2; i++) send(i < ok2);
      if (ok1 + bad1 + ok2 + bad2 < 4) strobe(1'b1);
    end
  endtask : run
endmodule : qa_host_model
`default_nettype wire

// File: qa_verdict_if.sv
`timescale 1ns/100ps
`default_nettype none
// Carries one cycle's verdict from the top to the fail counter
interface qa_verdict_if;
  logic end_pulse;
  logic pass;
  logic [3:0] limit;
  logic [3:0] fail_cnt;
  logic action;
  modport src (output end_pulse, output pass, output limit, input fail_cnt, input action);
  modport cnt (input end_pulse, input pass, input limit, output fail_cnt, output action);
endinterface : qa_verdict_if
`default_nettype wire

// File: qa_watchdog_answer_evaluator.sv
// Operation
// - Three right early, one right late: early restart, count down, new question.
// - Some right early, none late: wait window end, count up, set watchdog error.
// - Four answers with any wrong: restart at fourth, count up, both errors.
// - Under four answers with wrong ones: restart at window end, both errors.
// - Four answers in first window fail the cycle and restart at fourth.
// - Four early all right sets watchdog error only; else both errors.
// - None early, four wrong late: restart at fourth, count up, both errors.
// - Evaluation only runs while the answer scheme selects multi-answer mode.
// - Failure reaching the configured limit triggers the watchdog action.
//
// Implementation choices: register access over APB and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module qa_watchdog_answer_evaluator
(
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic SRST,
  // Answer events from the answer checker, same clock
  input wire logic ANSWER_VALID,
  input wire logic ANSWER_CORRECT,
  // Window timing from the window timer, same clock
  input wire logic WIN1_END,
  input wire logic WIN2_END,
  // Cycle results
  output logic NEW_CYCLE,
  output logic NEW_QUESTION,
  output logic WD_ACTION,
  output logic IRQ,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR
);
  import qa_eval_pkg::*;

  qa_verdict_if vd ();

  logic [1:0] answers_received_count_r;
  logic win2_r;
  logic early_r;
  logic any_wrong_r;
  logic win1_correct_r;
  logic win2_correct_r;
  logic answer_error_flag_r;
  logic watchdog_error_flag_r;
  logic answer_scheme_select_r;
  logic [3:0] limit_r;
  logic [IRQ_W-1:0] irq_stat_r;
  logic [IRQ_W-1:0] irq_mask_r;
  logic new_cycle_r;
  logic new_q_r;
  logic [31:0] prdata_r;
  logic fourth;
  logic win_done;
  logic active;
  logic cycle_end;
  logic fail;
  logic ans_err_nxt;
  logic watchdog_error_flag_nxt;
  logic [IRQ_W-1:0] events;
  logic wr;
  logic rd;
  logic pass_split;
  logic late_wrong;
  logic wr_ctrl;
  logic wr_stat;
  logic wr_mask;

  // Decode a register offset to a known location
  function automatic logic addr_hit(input logic [7:0] a);
    addr_hit = (a == ADDR_CTRL) || (a == ADDR_STATUS) || (a == ADDR_IRQ_STAT)
      || (a == ADDR_IRQ_MASK);
  endfunction : addr_hit

  assign active = (answer_scheme_select_r == SCHEME_MULTI);
  assign fourth = active && ANSWER_VALID && (answers_received_count_r == ANSW_CNT_LAST);
  // Cycle closes at the fourth answer or the end of the second window
  assign win_done = active && WIN2_END && !fourth;
  assign cycle_end = fourth || win_done;

  // Pass shape: three right early, none wrong, nothing right late yet
  assign pass_split = win2_r && early_r && win1_correct_r && !win2_correct_r && !any_wrong_r;
  // Wrong answer landing on the window end edge still counts
  assign late_wrong = active && ANSWER_VALID && !ANSWER_CORRECT;

  // Verdict evaluation for the closing cycle
  always_comb
  begin
    fail = 1'b1;
    ans_err_nxt = 1'b0;
    watchdog_error_flag_nxt = 1'b1;
    if (fourth)
    begin
      if (!win2_r)
      begin
        // All four early: failed even if all right
        fail = 1'b1;
        ans_err_nxt = any_wrong_r || !ANSWER_CORRECT;
      end
      else if (pass_split && ANSWER_CORRECT)
      begin
        // Exactly three right early, one right late
        fail = 1'b0;
        watchdog_error_flag_nxt = 1'b0;
      end
      else
        ans_err_nxt = any_wrong_r || !ANSWER_CORRECT;
    end
    else
      // Short count at window end; wrong answers add answer error
      ans_err_nxt = any_wrong_r || late_wrong;
  end

  // Two-bit answer count; cleared on cycle start
  always_ff @(posedge REF_CLK)
  begin
    if (SRST || cycle_end)
      answers_received_count_r <= ANSW_CNT_RST;
    else if (active && ANSWER_VALID)
      answers_received_count_r <= answers_received_count_r + 2'h1;
  end

  // Window tracking; second window opens at the first window end
  always_ff @(posedge REF_CLK)
  begin
    if (SRST || cycle_end)
      win2_r <= 1'b0;
    else if (active && WIN1_END)
      win2_r <= 1'b1;
  end

  // Any wrong answer in this cycle
  always_ff @(posedge REF_CLK)
  begin
    if (SRST || cycle_end)
      any_wrong_r <= 1'b0;
    else if (active && ANSWER_VALID && !ANSWER_CORRECT)
      any_wrong_r <= 1'b1;
  end

  // Right answers seen in each window
  always_ff @(posedge REF_CLK)
  begin
    if (SRST || cycle_end)
    begin
      win1_correct_r <= 1'b0;
      win2_correct_r <= 1'b0;
    end
    else if (active && ANSWER_VALID && ANSWER_CORRECT)
    begin
      if (win2_r)
        win2_correct_r <= 1'b1;
      else
        win1_correct_r <= 1'b1;
    end
  end

  // Third answer in window one marks the expected split
  always_ff @(posedge REF_CLK)
  begin
    if (SRST || cycle_end)
      early_r <= 1'b0;
    else if (active && ANSWER_VALID && !win2_r && answers_received_count_r == ANSW_CNT_THIRD)
      early_r <= 1'b1;
  end

  // Error status bits updated at every cycle close
  always_ff @(posedge REF_CLK)
  begin
    if (SRST)
    begin
      answer_error_flag_r <= 1'b0;
      watchdog_error_flag_r <= 1'b0;
    end
    else if (cycle_end)
    begin
      answer_error_flag_r <= ans_err_nxt;
      watchdog_error_flag_r <= watchdog_error_flag_nxt;
    end
  end

  // Cycle start and question select pulses
  always_ff @(posedge REF_CLK)
  begin
    if (SRST)
    begin
      new_cycle_r <= 1'b0;
      new_q_r <= 1'b0;
    end
    else
    begin
      new_cycle_r <= cycle_end;
      new_q_r <= cycle_end && !fail;
    end
  end

  // Fail counter lives in its own module
  assign vd.end_pulse = cycle_end;
  assign vd.pass = !fail;
  assign vd.limit = limit_r;
  qa_fail_counter u_fail
  (
    .clk(REF_CLK),
    .rst(SRST),
    .vd(vd)
  );

  // APB decode; zero wait states
  assign wr = PSEL && PENABLE && PWRITE;
  assign rd = PSEL && !PENABLE && !PWRITE;
  assign wr_ctrl = wr && (PADDR == ADDR_CTRL);
  assign wr_stat = wr && (PADDR == ADDR_IRQ_STAT);
  assign wr_mask = wr && (PADDR == ADDR_IRQ_MASK);

  // Configuration register
  always_ff @(posedge REF_CLK)
  begin
    if (SRST)
    begin
      answer_scheme_select_r <= SCHEME_MULTI;
      limit_r <= FAIL_LIMIT_RST;
    end
    else if (wr_ctrl)
    begin
      answer_scheme_select_r <= PWDATA[CTRL_SCHEME_BIT];
      limit_r <= PWDATA[CTRL_LIMIT_LSB +: FAIL_CNT_W];
    end
  end

  assign events[EV_CYCLE_END] = cycle_end;
  assign events[EV_FAIL] = cycle_end && fail;
  assign events[EV_ACTION] = vd.action;

  // Sticky interrupt status; a new event beats a write-one clear
  always_ff @(posedge REF_CLK)
  begin
    if (SRST)
      irq_stat_r <= '0;
    else if (wr_stat)
      irq_stat_r <= (irq_stat_r & ~PWDATA[IRQ_W-1:0]) | events;
    else
      irq_stat_r <= irq_stat_r | events;
  end

  // Interrupt mask
  always_ff @(posedge REF_CLK)
  begin
    if (SRST)
      irq_mask_r <= '0;
    else if (wr_mask)
      irq_mask_r <= PWDATA[IRQ_W-1:0];
  end

  // Read data captured in the setup cycle so it stands in the access phase
  always_ff @(posedge REF_CLK)
  begin
    if (SRST)
      prdata_r <= '0;
    else if (rd)
    begin
      prdata_r <= '0;
      unique case (PADDR)
        ADDR_CTRL:
        begin
          prdata_r[CTRL_SCHEME_BIT] <= answer_scheme_select_r;
          prdata_r[CTRL_LIMIT_LSB +: FAIL_CNT_W] <= limit_r;
        end
        ADDR_STATUS:
        begin
          prdata_r[ST_ANSW_ERR_BIT] <= answer_error_flag_r;
          prdata_r[ST_WATCHDOG_ERROR_FLAG_BIT] <= watchdog_error_flag_r;
          prdata_r[ST_ACTION_BIT] <= vd.action;
          prdata_r[ST_CNT_LSB +: ANSW_CNT_W] <= answers_received_count_r;
          prdata_r[ST_FAIL_LSB +: FAIL_CNT_W] <= vd.fail_cnt;
          prdata_r[ST_WIN2_BIT] <= win2_r;
        end
        ADDR_IRQ_STAT:
          prdata_r[IRQ_W-1:0] <= irq_stat_r;
        ADDR_IRQ_MASK:
          prdata_r[IRQ_W-1:0] <= irq_mask_r;
        default:
          prdata_r <= '0;
      endcase
    end
  end

  // Outputs
  assign PRDATA = prdata_r;
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !addr_hit(PADDR);
  assign NEW_CYCLE = new_cycle_r;
  assign NEW_QUESTION = new_q_r;
  assign WD_ACTION = vd.action;
  assign IRQ = |(irq_stat_r & irq_mask_r);
endmodule : qa_watchdog_answer_evaluator
`default_nettype wire

// File: qa_watchdog_answer_evaluator_tb.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin \
  $display("CHECK FAILED %s exp %h got %h", nm, e, g); bad_count++; end end
module qa_watchdog_answer_evaluator_tb;
  import qa_eval_pkg::*;
  logic clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, exp_rd;
  logic av, ac, w1, w2, nc, nq, act, irq, pready, pslverr, exp_q, act_x;
  logic [3:0] fc = 4'h0;
  int bad_count = 0, check_count = 0, n;
  logic nq_q[$];
  logic [31:0] rd_q[$];
  // Early ok, early bad, late ok, late bad, answer err, watchdog_error_flag, pass
  int sc[7][7] = '{'{1, 0, 0, 0, 0, 1, 0}, '{3, 0, 0, 1, 1, 1, 0}, '{0, 3, 0, 0, 1, 1, 0},
    '{4, 0, 0, 0, 0, 1, 0}, '{2, 2, 0, 0, 1, 1, 0}, '{0, 0, 0, 4, 1, 1, 0}, '{3, 0, 1, 0, 0, 0, 1}};
  // 125 MHz clock
  always #4 clk = ~clk;
  qa_host_model u_qa_host_model (.clk(clk), .answer_valid(av), .answer_correct(ac),
    .win1_end(w1), .win2_end(w2));
  qa_watchdog_answer_evaluator u_qa_watchdog_answer_evaluator (.REF_CLK(clk), .SRST(srst),
    .ANSWER_VALID(av), .ANSWER_CORRECT(ac), .WIN1_END(w1), .WIN2_END(w2), .NEW_CYCLE(nc),
    .NEW_QUESTION(nq), .WD_ACTION(act), .IRQ(irq), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr));
  task automatic end_of_test();
    if (bad_count == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_of_test
  // APB transfer, held until ready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1)
    begin
      bad_count++;
      end_of_test();
    end
    {psel, penable} <= 2'b00;
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    apb(1'b0, a, $urandom());
  endtask : rd
  // Cycle start awaited on falling edges so registered pulses have settled
  task automatic wait_cycle();
    for (n = 0; n < 40 && nc !== 1'b1; n++) @(negedge clk);
    if (n == 40)
    begin
      bad_count++;
      end_of_test();
    end
  endtask : wait_cycle
  // Bus monitor: error flag and read data at the completing edge
  always @(posedge clk)
    if (psel && penable && pready === 1'b1)
    begin
      `CHK("bus error", (paddr > 8'h0C) || (paddr[1:0] != 2'h0), pslverr)
      if (!pwrite)
      begin
        exp_rd = rd_q.pop_front();
        `CHK("read data", exp_rd, prdata)
      end
    end
  // Cycle monitor: any start with no note pending is a mismatch
  always @(negedge clk)
    if (nc === 1'b1)
    begin
      exp_q = (nq_q.size() == 0) ? 1'bx : nq_q.pop_front();
      `CHK("new question", exp_q, nq)
    end
  initial
  begin
    void'($urandom(11));
    act_x = 1'b0;
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    rd(ADDR_CTRL, 32'h0000_00F0);
    apb(1'b1, ADDR_CTRL, ($urandom() & 32'hFFFF_FF00) | 32'h0000_0060);
    for (int i = 0; i < 7; i++)
    begin
      nq_q.push_back(sc[i][6] != 0);
      if (sc[i][6] != 0)
        fc = (fc == 4'h0) ? fc : fc - 4'h1;
      else
        fc = (fc == 4'hF) ? fc : fc + 4'h1;
      act_x = act_x | (sc[i][6] == 0 && fc == 4'h6);
      u_qa_host_model.run(sc[i][0], sc[i][1], sc[i][2], sc[i][3]);
      wait_cycle();
      rd(ADDR_STATUS, {20'h0, fc, 5'h0, act_x, sc[i][5][0], sc[i][4][0]});
      @(negedge clk);
      `CHK("action pin", act_x, act)
    end
    apb(1'b1, ADDR_IRQ_MASK, 32'h1);
    @(negedge clk);
    `CHK("irq raised", 1'b1, irq)
    apb(1'b1, ADDR_IRQ_STAT, 32'h1);
    @(negedge clk);
    `CHK("irq cleared", 1'b0, irq)
    rd(ADDR_IRQ_STAT, 32'h6);
    apb(1'b1, 8'h10, $urandom());
    rd(8'h10, 32'h0);
    apb(1'b1, ADDR_CTRL, 32'h61);
    u_qa_host_model.run(3, 0, 1, 0);
    repeat (10) @(negedge clk);
    rd(ADDR_STATUS, {20'h0, fc, 5'h0, act_x, 2'b00});
    end_of_test();
  end
endmodule : qa_watchdog_answer_evaluator_tb
`default_nettype wire
